// *** design/fsrc_ctrl.v ***
// Fail-safe supervision and reset control with four byte-wide registers.
// Assumes a host register port on the same clock and fail-safe causes from pins.
`timescale 1ns/10ps
`include "fsrc_defs.vh"

// Notes on behaviour
// - Counting and the overflow action work only while the counter enable bit is set.
// - Over threshold: none, supply low 1 s, soft reset, power-on reset or sleep.
// - Action 100b ignores wake events and stays asleep until power cycle.
// - After actions 001b, 010b, 011b the sleep-wake-error timer starts when done.
// - Cause field reads 000b none, 001b thermal, 011b core undervoltage.
// - The cause holds until the host writes zero to the entry count.
// - Disable bit blocks fail-safe entry, except fail-safe during power-up.
// - Threshold field in bits 7-4 is entries needed minus one.
// - Entry count saturates at 15 and clears when zero is written.
// - Soft reset returns registers to defaults, supply-enable stays on; self-clearing.
// - Hard reset bit, self-clearing, performs a full power-on reset.
// - A commanded hard reset sets the power-up flag.
// - Supply-enable pin disable bit turns the pin off when set.
// - Function select: 0 supply-enable output, 1 fallback output.
// - Fallback disable bit turns the fallback output off.
// - Release method: third good trigger, first good trigger, host write.
// - With release method host write, writing one to the release bit turns fallback off; the bit self-clears.
// - The register port stays usable in sleep while the io supply is present.
module fsrc_ctrl #(
  parameter SUP_LOW_CYC = `FSRC_SUP_LOW_CYC
) (
  // Clock and reset.
  input  wire       ref_clk_in,
  input  wire       rst_in,
  // Host register port.
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  output reg  [7:0] reg_rdata_out,
  output wire       reg_ready_out,
  // Fail-safe causes and device state, asynchronous levels.
  input  wire       thermal_shutdown_in,
  input  wire       core_undervoltage_in,
  input  wire       power_up_in,
  input  wire       io_supply_in,
  input  wire       sleep_mode_in,
  // Watchdog trigger events, one-cycle pulses on this clock.
  input  wire       wd_good_trigger_in,
  // Events and pins.
  output wire       fail_safe_mode_out,
  output reg        soft_reset_out,
  output reg        power_on_reset_out,
  output reg        power_up_flag_set_out,
  output reg        sleep_wake_error_timer_start_out,
  output wire       ignore_wake_out,
  output wire       supply_enable_output_out,
  output wire       fallback_output_out
);

  // Register fields.
  reg        cntr_en_q;
  reg  [2:0] action_q;
  reg  [2:0] cause_q;
  reg        fail_safe_disable_q;
  reg  [3:0] threshold_q;
  reg  [3:0] count_q;
  reg        sup_dis_q;
  reg        func_sel_q;
  reg        fb_dis_q;
  reg  [1:0] rel_method_q;
  // Internal state.
  // The low-time counter is 32 bits wide so that the full 1 s at 100 MHz fits.
  reg        fs_mode_q;
  reg        sup_low_q;
  reg [31:0] sup_low_cnt_q;
  reg        sleep_lock_q;
  reg        fb_on_q;
  reg  [1:0] good_cnt_q;
  reg        soft_pend_q;
  reg        hard_pend_q;

  // Synchronised copies of the pin levels.
  wire       therm_s;
  wire       uv_s;
  wire       pwrup_s;
  wire       io_s;
  wire       sleep_s;

  // Synchronise the pin levels.
  // Every cause and state pin passes two flip-flops before any logic reads it,
  // so a level change reaches the logic two cycles after it shows on the pin.
  fsrc_sync #(
    .WIDTH(5)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({thermal_shutdown_in, core_undervoltage_in, power_up_in,
                  io_supply_in, sleep_mode_in}),
    .sync_out   ({therm_s, uv_s, pwrup_s, io_s, sleep_s})
  );

  // Address decode shared by reads and writes.
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Overflow action decode, shared by every action branch.
  function act_is;
    input [2:0] code;
    input [2:0] want;
    begin
      act_is = (code == want);
    end
  endfunction

  // Port access: always in awake mode, in sleep only with io supply.
  // A refused access is dropped, not held, so the host must watch ready.
  wire port_ok   = !sleep_s || io_s;
  wire wr_ok     = reg_wr_in && port_ok;
  wire wr_cfg    = wr_ok && hit(reg_addr_in, `FSRC_ADDR_FS_CONFIG);
  wire wr_cnt    = wr_ok && hit(reg_addr_in, `FSRC_ADDR_FS_COUNTER);
  wire wr_rst    = wr_ok && hit(reg_addr_in, `FSRC_ADDR_RESET_CMD);
  wire wr_pin    = wr_ok && hit(reg_addr_in, `FSRC_ADDR_PIN_CONFIG);
  assign reg_ready_out = port_ok;

  // Cause detection; power-up fail-safe ignores the disable bit.
  // Thermal shutdown wins over undervoltage when both are present, and a
  // power-up entry leaves the recorded cause unchanged.
  wire cause_any  = therm_s || uv_s;
  wire fs_req     = (cause_any && !fail_safe_disable_q) || pwrup_s;
  wire fs_entry   = fs_req && !fs_mode_q;
  wire [2:0] new_cause = therm_s ? `FSRC_CAUSE_THERMAL :
                         (uv_s ? `FSRC_CAUSE_CORE_UV : `FSRC_CAUSE_NONE);
  // Count after this entry, saturating at the maximum.
  wire [3:0] count_inc = (count_q == `FSRC_CNT_MAX) ? count_q : count_q + 4'h1;
  // The entry total is one bit wider than the field, so that a threshold of 15
  // (sixteen entries) is still exceeded once the shown count has saturated.
  // Every further entry past the threshold fires the action again.
  wire [4:0] entries_next = {1'b0, count_q} + 5'h01;
  // Threshold + 1 entries needed, so fire when the entry total exceeds threshold.
  wire overflow  = cntr_en_q && fs_entry &&
                   (entries_next > {1'b0, threshold_q});
  wire clear_cnt = wr_cnt && (reg_wdata_in[`FSRC_CNT_HI:`FSRC_CNT_LO] == 4'h0);
  wire soft_go   = wr_rst && reg_wdata_in[`FSRC_SOFT_RST_BIT];
  wire hard_go   = wr_rst && reg_wdata_in[`FSRC_HARD_RST_BIT];
  wire act_soft  = overflow && act_is(action_q, `FSRC_ACT_SOFT);
  wire act_hard  = overflow && act_is(action_q, `FSRC_ACT_HARD);
  wire act_sup_low = overflow && act_is(action_q, `FSRC_ACT_SUP_LOW);
  wire act_sleep = overflow && act_is(action_q, `FSRC_ACT_SLEEP);
  wire any_soft  = soft_go || act_soft || soft_pend_q;
  // Last cycle of the supply-enable low time.
  wire sup_low_done = sup_low_q && (sup_low_cnt_q == SUP_LOW_CYC - 32'h1);
  // Fallback release conditions, one for each release method.
  wire fb_rel_host  = wr_pin && reg_wdata_in[`FSRC_FB_REL_BIT] &&
                      (rel_method_q == `FSRC_REL_HOST_WRITE);
  wire fb_rel_first = wd_good_trigger_in && (rel_method_q == `FSRC_REL_FIRST_TRIG);
  wire fb_rel_third = wd_good_trigger_in && (rel_method_q == `FSRC_REL_THIRD_TRIG);

  // Configuration registers; soft reset returns them to defaults.
  // A write replaces the whole writable part of a register, and the soft reset
  // clears the overflow action and threshold as well.
  always @(posedge ref_clk_in)
  begin
    if (rst_in || any_soft)
    begin
      cntr_en_q    <= 1'b0;
      action_q     <= 3'h0;
      fail_safe_disable_q     <= 1'b0;
      threshold_q  <= 4'h0;
      sup_dis_q    <= 1'b0;
      func_sel_q   <= 1'b0;
      fb_dis_q     <= 1'b0;
      rel_method_q <= 2'h0;
    end
    else
    begin
      if (wr_cfg)
      begin
        cntr_en_q <= reg_wdata_in[`FSRC_CNTR_EN_BIT];
        action_q  <= reg_wdata_in[`FSRC_ACT_HI:`FSRC_ACT_LO];
        fail_safe_disable_q  <= reg_wdata_in[`FSRC_FAIL_SAFE_DISABLE_BIT];
      end
      if (wr_cnt)
        threshold_q <= reg_wdata_in[`FSRC_THR_HI:`FSRC_THR_LO];
      if (wr_pin)
      begin
        sup_dis_q    <= reg_wdata_in[`FSRC_SUP_DIS_BIT];
        func_sel_q   <= reg_wdata_in[`FSRC_FUNC_SEL_BIT];
        fb_dis_q     <= reg_wdata_in[`FSRC_FB_DIS_BIT];
        rel_method_q <= reg_wdata_in[`FSRC_REL_HI:`FSRC_REL_LO];
      end
    end
  end

  // Fail-safe mode follows the request and a soft reset does not clear it, so a
  // soft reset fired by an entry does not count the same cause a second time.
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      fs_mode_q <= 1'b0;
    else
      fs_mode_q <= fs_req;
  end

  // Entry count and cause; a new entry wins over a clearing write.
  // The count only moves while counting is enabled, but the cause is recorded
  // on every thermal or undervoltage entry so that the host can see why.
  always @(posedge ref_clk_in)
  begin
    if (rst_in || any_soft)
    begin
      count_q   <= 4'h0;
      cause_q   <= `FSRC_CAUSE_NONE;
    end
    else
    begin
      if (fs_entry && cntr_en_q)
        count_q <= count_inc;
      else if (clear_cnt)
        count_q <= 4'h0;
      if (fs_entry && (new_cause != `FSRC_CAUSE_NONE))
        cause_q <= new_cause;
      else if (clear_cnt)
        cause_q <= `FSRC_CAUSE_NONE;
    end
  end

  // Supply-enable low action and the sleep lock.
  // The low time counts from the entry edge, so the pin is low for exactly
  // SUP_LOW_CYC cycles; a new overflow during the low time restarts it.
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sup_low_q     <= 1'b0;
      sup_low_cnt_q <= 32'h0;
      sleep_lock_q  <= 1'b0;
    end
    else
    begin
      if (act_sup_low)
      begin
        sup_low_q     <= 1'b1;
        sup_low_cnt_q <= 32'h0;
      end
      else if (sup_low_q)
      begin
        if (sup_low_done)
          sup_low_q <= 1'b0;
        sup_low_cnt_q <= sup_low_cnt_q + 32'h1;
      end
      // Only a power cycle, that is rst_in, releases the lock.
      if (act_sleep)
        sleep_lock_q <= 1'b1;
    end
  end

  // Soft and hard reset commands, one-cycle pulses.
  // The hard reset itself is carried out outside this block: the pulse asks
  // for it, and the sleep-wake-error timer start follows one cycle later.
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      soft_pend_q           <= 1'b0;
      hard_pend_q           <= 1'b0;
      soft_reset_out        <= 1'b0;
      power_on_reset_out    <= 1'b0;
      power_up_flag_set_out <= 1'b0;
      sleep_wake_error_timer_start_out <= 1'b0;
    end
    else
    begin
      // Holds the registers at their defaults for one more cycle.
      soft_pend_q           <= soft_go || act_soft;
      hard_pend_q           <= hard_go || act_hard;
      soft_reset_out        <= soft_go || act_soft;
      power_on_reset_out    <= hard_go || act_hard;
      power_up_flag_set_out <= hard_go;
      // Timer starts with the overflow soft reset pulse, one cycle after the power-on reset pulse, or the cycle after the low time ends.
      sleep_wake_error_timer_start_out <= act_soft || hard_pend_q ||
                                          sup_low_done;
    end
  end

  // Fallback output state and its release methods. The release bit is a
  // strobe that is never stored, so it reads as zero and clears itself.
  always @(posedge ref_clk_in)
  begin
    if (rst_in || any_soft)
    begin
      fb_on_q    <= 1'b1;
      good_cnt_q <= 2'h0;
    end
    else if (fb_rel_host)
      fb_on_q <= 1'b0;
    else if (fb_on_q && fb_rel_first)
      fb_on_q <= 1'b0;
    else if (fb_on_q && fb_rel_third)
    begin
      if (good_cnt_q == 2'h2)
        fb_on_q <= 1'b0;
      good_cnt_q <= good_cnt_q + 2'h1;
    end
  end

  // Shared pin function.
  // The supply-enable output stays on through a soft reset, since only the
  // overflow low time, the disable bit and function select 1 can turn it off.
  assign supply_enable_output_out = !func_sel_q && !sup_dis_q && !sup_low_q;
  assign fallback_output_out      = func_sel_q && !fb_dis_q && fb_on_q;
  assign fail_safe_mode_out       = fs_mode_q;
  assign ignore_wake_out          = sleep_lock_q;

  // Read data; self-clearing bits read as zero.
  // Reads are registered, so data stands from the cycle after the read until
  // the next accepted read.
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in && port_ok)
    begin
      if (hit(reg_addr_in, `FSRC_ADDR_FS_CONFIG))
        reg_rdata_out <= {cntr_en_q, action_q, cause_q, fail_safe_disable_q};
      else if (hit(reg_addr_in, `FSRC_ADDR_FS_COUNTER))
        reg_rdata_out <= {threshold_q, count_q};
      else if (hit(reg_addr_in, `FSRC_ADDR_PIN_CONFIG))
        reg_rdata_out <= {1'b0, sup_dis_q, func_sel_q, fb_dis_q, rel_method_q, 2'h0};
      else
        reg_rdata_out <= 8'h00;
    end
  end

endmodule // fsrc_ctrl

// *** design/fsrc_defs.vh ***
// Register map, field positions and timing counts for the fail-safe reset controller.
// Assumes a 100 MHz device clock; included by the design files by bare name.
`ifndef FSRC_DEFS_VH
`define FSRC_DEFS_VH

// Register offsets.
`define FSRC_ADDR_FS_CONFIG     8'h17
`define FSRC_ADDR_FS_COUNTER    8'h18
`define FSRC_ADDR_RESET_CMD     8'h19
`define FSRC_ADDR_PIN_CONFIG    8'h1A

// Reset values.
`define FSRC_RST_FS_CONFIG      8'h00
`define FSRC_RST_FS_COUNTER     8'h00
`define FSRC_RST_PIN_CONFIG     8'h00

// Fail-safe configuration fields.
`define FSRC_CNTR_EN_BIT        7
`define FSRC_ACT_HI             6
`define FSRC_ACT_LO             4
`define FSRC_CAUSE_HI           3
`define FSRC_CAUSE_LO           1
`define FSRC_FAIL_SAFE_DISABLE_BIT         0

// Counter register fields.
`define FSRC_THR_HI             7
`define FSRC_THR_LO             4
`define FSRC_CNT_HI             3
`define FSRC_CNT_LO             0
`define FSRC_CNT_MAX            4'hF

// Reset command fields.
`define FSRC_SOFT_RST_BIT       1
`define FSRC_HARD_RST_BIT       0

// Pin configuration fields.
`define FSRC_SUP_DIS_BIT        6
`define FSRC_FUNC_SEL_BIT       5
`define FSRC_FB_DIS_BIT         4
`define FSRC_REL_HI             3
`define FSRC_REL_LO             2
`define FSRC_FB_REL_BIT         1

// Overflow action codes.
`define FSRC_ACT_NONE           3'h0
`define FSRC_ACT_SUP_LOW        3'h1
`define FSRC_ACT_SOFT           3'h2
`define FSRC_ACT_HARD           3'h3
`define FSRC_ACT_SLEEP          3'h4

// Fail-safe cause codes.
`define FSRC_CAUSE_NONE         3'h0
`define FSRC_CAUSE_THERMAL      3'h1
`define FSRC_CAUSE_CORE_UV      3'h3

// Fallback release methods.
`define FSRC_REL_THIRD_TRIG     2'h0
`define FSRC_REL_FIRST_TRIG     2'h1
`define FSRC_REL_HOST_WRITE     2'h2

// Timing: supply-enable low time of the overflow action, 1 s of 100 MHz cycles.
`define FSRC_SUP_LOW_CYC        32'h05F5E100

`endif

// *** design/fsrc_sync.v ***
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes the inputs are quasi-static levels from pins.
`timescale 1ns/10ps
module fsrc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input  wire             ref_clk_in,
  input  wire             rst_in,
  // Levels.
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // The first stage is read only by the second.
  always @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // fsrc_sync

// *** sim/fsrc_ctrl_properties.sv ***
// Port checker for the fail-safe reset controller.
// Assumes it is bound to fsrc_ctrl and sees only its ports.
`timescale 1ns/10ps
module fsrc_ctrl_properties (
  // Clock and reset.
  input wire       ref_clk_in,
  input wire       rst_in,
  // Host port.
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_ready_out,
  // Levels, events and pins.
  input wire       io_supply_in,
  input wire       sleep_mode_in,
  input wire       soft_reset_out,
  input wire       power_on_reset_out,
  input wire       power_up_flag_set_out,
  input wire       sleep_wake_error_timer_start_out,
  input wire       ignore_wake_out,
  input wire       supply_enable_output_out,
  input wire       fallback_output_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // Accepted accesses decoded by address.
  wire wr_rst = reg_wr_in && reg_ready_out && reg_addr_in == 8'h19;
  wire wr_pin = reg_wr_in && reg_ready_out && reg_addr_in == 8'h1A;
  wire rd_zero = reg_rd_in && reg_ready_out && reg_addr_in == 8'h19;
  // Steps of a commanded power-on reset.
  sequence s_por;
    power_on_reset_out && power_up_flag_set_out;
  endsequence
  sequence s_timer;
    sleep_wake_error_timer_start_out;
  endsequence
  a_soft_cmd_pulse: assert property (wr_rst && reg_wdata_in[1] |=> soft_reset_out)
    else $error("soft reset pulse missing");
  a_hard_cmd_steps: assert property (wr_rst && reg_wdata_in[0] && !reg_wdata_in[1]
    |=> s_por ##1 s_timer) else $error("hard reset steps wrong");
  a_supply_off: assert property (wr_pin && reg_wdata_in[6] |=> !supply_enable_output_out)
    else $error("supply output not disabled");
  a_select_supply: assert property (wr_pin && !reg_wdata_in[5] |=> !fallback_output_out)
    else $error("fallback active while not selected");
  a_fallback_off: assert property (wr_pin && reg_wdata_in[5:4] == 2'h3
    |=> !fallback_output_out) else $error("fallback not disabled");
  a_sleep_refuse: assert property ((sleep_mode_in && !io_supply_in) [*4]
    |-> !reg_ready_out) else $error("port usable without io supply");
  a_io_ready: assert property (io_supply_in [*4] |-> reg_ready_out)
    else $error("port refused with io supply");
  a_zero_read: assert property (rd_zero |=> reg_rdata_out == 8'h00)
    else $error("reset command bits read back");
  a_wake_ignore_held: assert property (ignore_wake_out |=> ignore_wake_out)
    else $error("wake ignore released");
endmodule // fsrc_ctrl_properties

bind fsrc_ctrl fsrc_ctrl_properties fsrc_ctrl_properties_inst (.*);

// *** sim/fsrc_ctrl_tb.sv ***
// Self-checking bench for the fail-safe reset controller.
// Assumes the host model drives the register port and the bench the pins.
`timescale 1ns/10ps
module fsrc_ctrl_tb;
  // Design ports, named as on the design.
  reg        ref_clk_in = 1'b0;
  reg        rst_in = 1'b1;
  reg        thermal_shutdown_in = 1'b0, core_undervoltage_in = 1'b0, power_up_in = 1'b0;
  reg        io_supply_in = 1'b1, sleep_mode_in = 1'b0, wd_good_trigger_in = 1'b0;
  wire       reg_wr_in, reg_rd_in, reg_ready_out, fail_safe_mode_out, soft_reset_out;
  wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire       power_on_reset_out, power_up_flag_set_out, sleep_wake_error_timer_start_out;
  wire       ignore_wake_out, supply_enable_output_out, fallback_output_out;
  integer    err_count = 0, n_compared = 0, i, s0, p0, f0, w0;
  integer    soft_n = 0, por_n = 0, flag_n = 0, swe_n = 0, low_n = 0;
  reg [7:0]  rv;

  fsrc_ctrl #(.SUP_LOW_CYC(10)) fsrc_ctrl_inst (.*);
  fsrc_host_model fsrc_host_model_inst (
    .ref_clk_in (ref_clk_in),
    .wr_out     (reg_wr_in),
    .rd_out     (reg_rd_in),
    .addr_out   (reg_addr_in),
    .data_out   (reg_wdata_in),
    .rdata_in   (reg_rdata_out)
  );

  // Clock at 100 MHz.
  always #5 ref_clk_in = ~ref_clk_in;
  // Counts event pulses and supply-low cycles.
  always @(posedge ref_clk_in)
  begin
    soft_n <= soft_n + (soft_reset_out === 1'b1);
    por_n <= por_n + (power_on_reset_out === 1'b1);
    flag_n <= flag_n + (power_up_flag_set_out === 1'b1);
    swe_n <= swe_n + (sleep_wake_error_timer_start_out === 1'b1);
    low_n <= low_n + (supply_enable_output_out === 1'b0);
  end

  task check(input string what, input [7:0] seen, input [7:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  task w(input [7:0] a, input [7:0] d);
  begin
    fsrc_host_model_inst.xfer(1'b1, a, d, rv);
  end
  endtask
  task r(input [7:0] a, input [7:0] e);
  begin
    fsrc_host_model_inst.xfer(1'b0, a, 8'h00, rv);
    check($sformatf("reg %h", a), rv, e);
  end
  endtask
  // Holds one cause pin high long enough to pass the synchroniser.
  task fs_entry(input integer which);
  begin
    @(negedge ref_clk_in);
    {power_up_in, core_undervoltage_in, thermal_shutdown_in} = 3'h1 << which;
    repeat (20) @(negedge ref_clk_in);
    {power_up_in, core_undervoltage_in, thermal_shutdown_in} = 3'h0;
    repeat (6) @(negedge ref_clk_in);
  end
  endtask
  task pulse_wd(input integer n);
  begin
    repeat (n)
    begin
      @(negedge ref_clk_in);
      wd_good_trigger_in = 1'b1;
      @(negedge ref_clk_in);
      wd_good_trigger_in = 1'b0;
    end
  end
  endtask
  task do_reset;
  begin
    @(negedge ref_clk_in);
    rst_in = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    rst_in = 1'b0;
  end
  endtask
  task t_defaults;
  begin
    for (i = 0; i < 5; i = i + 1)
      r(8'(8'h17 + i), 8'h00);
    check("sup", 8'(supply_enable_output_out), 8'h01);
    $display("test defaults done");
  end
  endtask
  task t_count;
  begin
    w(8'h17, 8'hA0);
    w(8'h18, 8'h10);
    fs_entry(0);
    r(8'h18, 8'h11);
    r(8'h17, 8'hA2);
    w(8'h18, 8'h10);
    r(8'h17, 8'hA0);
    s0 = soft_n;
    fs_entry(1);
    r(8'h17, 8'hA6);
    fs_entry(1);
    check("soft", 8'(soft_n - s0), 8'h01);
    r(8'h17, 8'h00);
    $display("test count done");
  end
  endtask
  task t_actions;
  begin
    for (i = 0; i < 5; i = i + 1)
    begin
      w(8'h18, 8'h00);
      w(8'h17, 8'(8'h80 | (i << 4)));
      s0 = soft_n;
      p0 = por_n;
      w0 = swe_n;
      low_n = 0;
      fs_entry(0);
      check("soft", 8'(soft_n - s0), 8'(i == 2));
      check("por", 8'(por_n - p0), 8'(i == 3));
      check("timer", 8'(swe_n - w0), 8'(i > 0 && i < 4));
      check("low", 8'(low_n), (i == 1) ? 8'h0A : 8'h00);
      check("ignore", 8'(ignore_wake_out), 8'(i == 4));
    end
    do_reset();
    w(8'h17, 8'h90);
    w(8'h18, 8'hF0);
    low_n = 0;
    repeat (16) fs_entry(0);
    r(8'h18, 8'hFF);
    check("low", 8'(low_n), 8'h0A);
    w(8'h18, 8'hF0);
    r(8'h18, 8'hF0);
    w(8'h17, 8'h81);
    fs_entry(0);
    r(8'h18, 8'hF0);
    fs_entry(2);
    r(8'h18, 8'hF1);
    w(8'h17, 8'h00);
    w(8'h18, 8'h00);
    fs_entry(0);
    r(8'h18, 8'h00);
    $display("test actions done");
  end
  endtask
  task t_pins;
  begin
    w(8'h1A, 8'h40);
    check("sup", 8'(supply_enable_output_out), 8'h00);
    w(8'h1A, 8'h30);
    check("fb", 8'(fallback_output_out), 8'h00);
    w(8'h1A, 8'h28);
    pulse_wd(3);
    check("fb", 8'(fallback_output_out), 8'h01);
    w(8'h1A, 8'h2A);
    check("fb", 8'(fallback_output_out), 8'h00);
    r(8'h1A, 8'h28);
    for (i = 0; i < 2; i = i + 1)
    begin
      w(8'h19, 8'h02);
      w(8'h1A, 8'(8'h20 | (i << 2)));
      pulse_wd(2 - 2 * i);
      check("fb", 8'(fallback_output_out), 8'h01);
      pulse_wd(1);
      check("fb", 8'(fallback_output_out), 8'h00);
    end
    $display("test pins done");
  end
  endtask
  task t_sleep_hard;
  begin
    w(8'h1A, 8'h00);
    sleep_mode_in = 1'b1;
    io_supply_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    check("ready", 8'(reg_ready_out), 8'h00);
    w(8'h1A, 8'h40);
    io_supply_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    r(8'h1A, 8'h00);
    w(8'h1A, 8'h40);
    r(8'h1A, 8'h40);
    sleep_mode_in = 1'b0;
    p0 = por_n;
    f0 = flag_n;
    w(8'h19, 8'h01);
    r(8'h19, 8'h00);
    check("por", 8'(por_n - p0), 8'h01);
    check("flag", 8'(flag_n - f0), 8'h01);
    thermal_shutdown_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    check("fsm", 8'(fail_safe_mode_out), 8'h01);
    thermal_shutdown_in = 1'b0;
    repeat (4) @(negedge ref_clk_in);
    check("fsm", 8'(fail_safe_mode_out), 8'h00);
    $display("test sleep and hard reset done");
  end
  endtask
  task close_out;
  begin
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // Main sequence.
  initial
  begin
    do_reset();
    t_defaults();
    t_count();
    t_actions();
    t_pins();
    t_sleep_hard();
    close_out();
  end
  // Watchdog well beyond the expected run of some 900 cycles.
  initial
  begin
    #200000;
    err_count = err_count + 1;
    close_out();
  end
endmodule // fsrc_ctrl_tb

// *** sim/fsrc_host_model.sv ***
// Host model driving the byte-wide register port.
// Assumes calls from the bench; lines change at the falling edge.
`timescale 1ns/10ps
module fsrc_host_model (
  // Clock.
  input  wire       ref_clk_in,
  // Register port.
  output reg        wr_out,
  output reg        rd_out,
  output reg  [7:0] addr_out,
  output reg  [7:0] data_out,
  input  wire [7:0] rdata_in
);
  // Port starts idle.
  initial
  begin
    {wr_out, rd_out, addr_out, data_out} = 18'h0;
  end
  // One strobe cycle; idle lines then show the inverse so stale values never match.
  task xfer(input wr, input [7:0] a, input [7:0] d, output [7:0] q);
  begin
    @(negedge ref_clk_in);
    {wr_out, rd_out, addr_out, data_out} = {wr, !wr, a, d};
    @(negedge ref_clk_in);
    q = rdata_in;
    {wr_out, rd_out, addr_out, data_out} = {2'b00, ~a, ~d};
  end
  endtask
endmodule // fsrc_host_model
